// ==== inc/slec_pkg.sv ====
package slec_pkg;
    // Register byte addresses (printed offsets are not all multiples of four: index x4)
    localparam logic [11:0] SLEC_IDX_LANE_A = 12'h20A;
    localparam logic [11:0] SLEC_IDX_LANE_B = 12'h20B;
    localparam logic [13:0] SLEC_ADDR_LANE_A = {SLEC_IDX_LANE_A, 2'b00};
    localparam logic [13:0] SLEC_ADDR_LANE_B = {SLEC_IDX_LANE_B, 2'b00};
    localparam logic [13:0] SLEC_ADDR_LINK_CTRL = 14'h0840;
    localparam logic [13:0] SLEC_ADDR_STATUS = 14'h0844;
    // Field layout
    localparam int SLEC_REG_W = 8;
    localparam int SLEC_SER_BIT = 0;
    localparam int SLEC_LANE_LSB = 1;
    localparam int SLEC_LANE_MSB = 7;
    localparam int SLEC_CTRL_ENC_BIT = 0;
    localparam int SLEC_CTRL_PDA_BIT = 1;
    localparam int SLEC_CTRL_PDB_BIT = 2;
    localparam logic [7:0] SLEC_RESET_VAL = 8'h00;
    localparam logic [2:0] SLEC_CTRL_RESET = 3'h0;
endpackage : slec_pkg

// ==== src/slec_spare_lanes.sv ====
`timescale 1ns/1ns
//==========================================================
module slec_spare_lanes import slec_pkg::*; #(
    parameter int LANES = 7
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [LANES-1:0] laneClkEnA,
    output logic [LANES-1:0] laneClkEnB,
    output logic [LANES-1:0] serClkEnA,
    output logic [LANES-1:0] serClkEnB,
    output logic linkEncoderEnable
);

    //==========================================================
    // Register file
    logic [7:0] spareA_q, spareA_d, spareB_q, spareB_d;
    logic [2:0] ctrl_q, ctrl_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic setup, hit;

    assign setup = psel && !penable;

    always_comb begin
        spareA_d = spareA_q;
        spareB_d = spareB_q;
        ctrl_d = ctrl_q;
        prdata_d = 32'h0000_0000;
        pready_d = setup;
        pslverr_d = 1'b0;
        hit = 1'b1;
        if (setup) begin
            unique case (paddr)
                SLEC_ADDR_LANE_A: begin
                    prdata_d = {24'h000000, spareA_q};
                    // Write ignored while encoder runs
                    if (pwrite && !ctrl_q[SLEC_CTRL_ENC_BIT]) begin
                        spareA_d = pwdata[7:0];
                    end
                end
                SLEC_ADDR_LANE_B: begin
                    prdata_d = {24'h000000, spareB_q};
                    if (pwrite && !ctrl_q[SLEC_CTRL_ENC_BIT]) begin
                        spareB_d = pwdata[7:0];
                    end
                end
                SLEC_ADDR_LINK_CTRL: begin
                    prdata_d = {29'h00000000, ctrl_q};
                    if (pwrite) begin
                        ctrl_d = pwdata[2:0];
                    end
                end
                SLEC_ADDR_STATUS: begin
                    prdata_d = {4'h0, serClkEnB, serClkEnA, laneClkEnB, laneClkEnA};
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            pslverr_d = !hit;
            if (pwrite) begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            spareA_q <= SLEC_RESET_VAL;
            spareB_q <= SLEC_RESET_VAL;
            ctrl_q <= SLEC_CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            spareA_q <= spareA_d;
            spareB_q <= spareB_d;
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    //==========================================================
    // Lane enable outputs
    // Serializer n needs lanes 0 to n on and the serializer bit set; lane 0 is gated like the others
    function automatic logic [LANES-1:0] serChain(input logic [LANES-1:0] lanes,
                                                  input logic serOn);
        logic run;
        run = serOn;
        serChain = '0;
        for (int n = 0; n < LANES; n++) begin
            run = run && lanes[n];
            serChain[n] = run;
        end
    endfunction : serChain

    logic [LANES-1:0] laneA_d, laneB_d, serA_d, serB_d;
    logic [LANES-1:0] laneA_q, laneB_q, serA_q, serB_q;
    logic enc_q, linkAOk, linkBOk;

    always_comb begin
        // Power-down overrides spare enables
        linkAOk = ctrl_q[SLEC_CTRL_ENC_BIT] && !ctrl_q[SLEC_CTRL_PDA_BIT];
        linkBOk = ctrl_q[SLEC_CTRL_ENC_BIT] && !ctrl_q[SLEC_CTRL_PDB_BIT];
        // Rate comes from the link itself; only gating here
        laneA_d = linkAOk ? spareA_q[SLEC_LANE_MSB:SLEC_LANE_LSB] : '0;
        laneB_d = linkBOk ? spareB_q[SLEC_LANE_MSB:SLEC_LANE_LSB] : '0;
        serA_d = serChain(laneA_d, spareA_q[SLEC_SER_BIT]);
        serB_d = serChain(laneB_d, spareB_q[SLEC_SER_BIT]);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            laneA_q <= '0;
            laneB_q <= '0;
            serA_q <= '0;
            serB_q <= '0;
            enc_q <= 1'b0;
        end else begin
            laneA_q <= laneA_d;
            laneB_q <= laneB_d;
            serA_q <= serA_d;
            serB_q <= serB_d;
            enc_q <= ctrl_q[SLEC_CTRL_ENC_BIT];
        end
    end

    assign laneClkEnA = laneA_q;
    assign laneClkEnB = laneB_q;
    assign serClkEnA = serA_q;
    assign serClkEnB = serB_q;
    assign linkEncoderEnable = enc_q;

    //==========================================================
    // Checks
    property p_laneA;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> laneClkEnA == ($past(linkAOk) ? $past(spareA_q[7:1]) : 7'h00);
    endproperty
    a_laneA: assert property (p_laneA) else $error("lane A enable wrong");

    property p_laneB;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> laneClkEnB == ($past(linkBOk) ? $past(spareB_q[7:1]) : 7'h00);
    endproperty
    a_laneB: assert property (p_laneB) else $error("lane B enable wrong");

    property p_serOff;
        @(posedge ref_clk) disable iff (!nrst)
        !spareA_q[0] && !spareB_q[0] |=> serClkEnA == 7'h00 && serClkEnB == 7'h00;
    endproperty
    a_serOff: assert property (p_serOff) else $error("serializer on without bit 0");

    property p_noWriteWhileEnc;
        @(posedge ref_clk) disable iff (!nrst)
        ctrl_q[0] |=> $stable(spareA_q) && $stable(spareB_q);
    endproperty
    a_noWriteWhileEnc: assert property (p_noWriteWhileEnc) else $error("spare changed live");

    property p_pdA;
        @(posedge ref_clk) disable iff (!nrst)
        ctrl_q[1] |=> laneClkEnA == 7'h00 && serClkEnA == 7'h00;
    endproperty
    a_pdA: assert property (p_pdA) else $error("lanes A on while powered down");

    property p_chain;
        @(posedge ref_clk) disable iff (!nrst)
        serClkEnA[1] |-> serClkEnA[0] && laneClkEnA[1] && laneClkEnA[0];
    endproperty
    a_chain: assert property (p_chain) else $error("serializer chain broken");

    property p_readBack;
        @(posedge ref_clk) disable iff (!nrst)
        setup && !pwrite && paddr == SLEC_ADDR_LANE_B |=> prdata[7:0] == $past(spareB_q);
    endproperty
    a_readBack: assert property (p_readBack) else $error("read back wrong");

    property p_readNoEffect;
        @(posedge ref_clk) disable iff (!nrst)
        setup && !pwrite |=> $stable(spareA_q) && $stable(spareB_q);
    endproperty
    a_readNoEffect: assert property (p_readNoEffect) else $error("read had effect");

    property p_pdB;
        @(posedge ref_clk) disable iff (!nrst)
        ctrl_q[SLEC_CTRL_PDB_BIT] |=> laneClkEnB == 7'h00 && serClkEnB == 7'h00;
    endproperty
    a_pdB: assert property (p_pdB) else $error("lanes B on while powered down");

    property p_encOffA;
        @(posedge ref_clk) disable iff (!nrst)
        !ctrl_q[SLEC_CTRL_ENC_BIT] |=> laneClkEnA == 7'h00 && serClkEnA == 7'h00;
    endproperty
    a_encOffA: assert property (p_encOffA) else $error("lanes A on with link off");

    property p_encOffB;
        @(posedge ref_clk) disable iff (!nrst)
        !ctrl_q[SLEC_CTRL_ENC_BIT] |=> laneClkEnB == 7'h00 && serClkEnB == 7'h00;
    endproperty
    a_encOffB: assert property (p_encOffB) else $error("lanes B on with link off");

    property p_chainB;
        @(posedge ref_clk) disable iff (!nrst)
        serClkEnB[1] |-> serClkEnB[0] && laneClkEnB[1] && laneClkEnB[0];
    endproperty
    a_chainB: assert property (p_chainB) else $error("serializer chain B broken");

    property p_serBaseA;
        @(posedge ref_clk) disable iff (!nrst)
        serClkEnA[0] |-> laneClkEnA[0];
    endproperty
    a_serBaseA: assert property (p_serBaseA) else $error("serializer A1 without lane");

    property p_serTopA;
        @(posedge ref_clk) disable iff (!nrst)
        serClkEnA[6] |-> laneClkEnA == 7'h7F;
    endproperty
    a_serTopA: assert property (p_serTopA) else $error("serializer A7 without lanes");

    property p_serTopB;
        @(posedge ref_clk) disable iff (!nrst)
        serClkEnB[6] |-> laneClkEnB == 7'h7F;
    endproperty
    a_serTopB: assert property (p_serTopB) else $error("serializer B7 without lanes");

    property p_serOnA;
        @(posedge ref_clk) disable iff (!nrst)
        linkAOk && spareA_q[0] && spareA_q[1] |=> serClkEnA[0];
    endproperty
    a_serOnA: assert property (p_serOnA) else $error("serializer A1 not powered");

    property p_serOnB;
        @(posedge ref_clk) disable iff (!nrst)
        linkBOk && spareB_q[0] && spareB_q[1] |=> serClkEnB[0];
    endproperty
    a_serOnB: assert property (p_serOnB) else $error("serializer B1 not powered");

    property p_readBackA;
        @(posedge ref_clk) disable iff (!nrst)
        setup && !pwrite && paddr == SLEC_ADDR_LANE_A |=> prdata[7:0] == $past(spareA_q);
    endproperty
    a_readBackA: assert property (p_readBackA) else $error("read back A wrong");

    property p_readyAfterSetup;
        @(posedge ref_clk) disable iff (!nrst)
        setup |=> pready;
    endproperty
    a_readyAfterSetup: assert property (p_readyAfterSetup) else $error("no ready after setup");

    property p_readyPulse;
        @(posedge ref_clk) disable iff (!nrst)
        pready |=> !pready;
    endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("ready longer than one cycle");

    property p_errWithReady;
        @(posedge ref_clk) disable iff (!nrst)
        pslverr |-> pready;
    endproperty
    a_errWithReady: assert property (p_errWithReady) else $error("error without ready");

    property p_writeZero;
        @(posedge ref_clk) disable iff (!nrst)
        setup && pwrite |=> prdata == 32'h0000_0000;
    endproperty
    a_writeZero: assert property (p_writeZero) else $error("read data on a write");

    property p_writeA;
        @(posedge ref_clk) disable iff (!nrst)
        setup && pwrite && paddr == SLEC_ADDR_LANE_A && !ctrl_q[SLEC_CTRL_ENC_BIT]
            |=> spareA_q == $past(pwdata[7:0]);
    endproperty
    a_writeA: assert property (p_writeA) else $error("write A lost");

    property p_writeB;
        @(posedge ref_clk) disable iff (!nrst)
        setup && pwrite && paddr == SLEC_ADDR_LANE_B && !ctrl_q[SLEC_CTRL_ENC_BIT]
            |=> spareB_q == $past(pwdata[7:0]);
    endproperty
    a_writeB: assert property (p_writeB) else $error("write B lost");

    property p_ctrlRead;
        @(posedge ref_clk) disable iff (!nrst)
        setup && !pwrite && paddr == SLEC_ADDR_LINK_CTRL |=> prdata[2:0] == $past(ctrl_q);
    endproperty
    a_ctrlRead: assert property (p_ctrlRead) else $error("control read back wrong");

endmodule : slec_spare_lanes

// ==== verification/slec_lane_rx.sv ====
`timescale 1ns/1ns
// ====
// Receiver side: counts lanes carrying data
module slec_lane_rx (
    input wire logic [6:0] laneClk,
    input wire logic [6:0] serClk,
    output logic [3:0] liveLanes
);
    always_comb begin
        liveLanes = 4'h0;
        for (int k = 0; k < 7; k++) begin
            liveLanes = liveLanes + 4'(laneClk[k] & serClk[k]);
        end
    end
endmodule : slec_lane_rx

// ==== verification/test_spare_lane_enable_control.sv ====
`timescale 1ns/1ns
module test_spare_lane_enable_control import slec_pkg::*;;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, enc, err;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] laneA, laneB, serA, serB;
    logic [3:0] liveA, liveB;
    logic [7:0] mA, mB;
    logic [2:0] mC;
    int miscompares, nCompared;
    int seed = 32'h972c;
    slec_spare_lanes u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .laneClkEnA(laneA), .laneClkEnB(laneB), .serClkEnA(serA),
        .serClkEnB(serB), .linkEncoderEnable(enc));
    slec_lane_rx u_rxA (.laneClk(laneA), .serClk(serA), .liveLanes(liveA));
    slec_lane_rx u_rxB (.laneClk(laneB), .serClk(serB), .liveLanes(liveB));
    // ====
    // Reference model and bus tasks
    function automatic logic [6:0] lanes(input logic [7:0] r, input logic pd);
        return (mC[0] && !pd) ? r[7:1] : 7'h00;
    endfunction : lanes
    function automatic logic [6:0] sers(input logic [7:0] r, input logic pd);
        logic run;
        logic [6:0] s;
        run = 1'b1;
        for (int k = 0; k < 7; k++) begin
            run = run & r[k + 1];
            s[k] = run & r[0] & mC[0] & !pd;
        end
        return s;
    endfunction : sers
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task summarize;
        if (miscompares == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    task xfer(input logic wr, input logic [13:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            miscompares++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        xfer(1'b0, SLEC_ADDR_LANE_A, 32'h0);
        check("regA", rd, 32'h0);
        xfer(1'b0, SLEC_ADDR_LANE_B, 32'h0);
        check("regB", rd, 32'h0);
        for (int t = 0; t < 24; t++) begin
            mA = (t == 0) ? 8'hFF : 8'($random(seed));
            mB = 8'($random(seed));
            mC = {2'($random(seed)), 1'b1};
            xfer(1'b1, SLEC_ADDR_LINK_CTRL, 32'h0);
            xfer(1'b1, SLEC_ADDR_LANE_A, {24'h0, mA});
            check("offA", {25'h0, laneA}, 32'h0);
            xfer(1'b1, SLEC_ADDR_LANE_B, {24'h0, mB});
            xfer(1'b0, SLEC_ADDR_LANE_B, 32'h0);
            check("rdB", rd, {24'h0, mB});
            xfer(1'b1, SLEC_ADDR_LINK_CTRL, {29'h0, mC});
            xfer(1'b1, SLEC_ADDR_LANE_A, {24'h0, ~mA});
            check("laneA", {25'h0, laneA}, {25'h0, lanes(mA, mC[1])});
            check("laneB", {25'h0, laneB}, {25'h0, lanes(mB, mC[2])});
            check("serA", {25'h0, serA}, {25'h0, sers(mA, mC[1])});
            check("serB", {25'h0, serB}, {25'h0, sers(mB, mC[2])});
            check("enc", {31'h0, enc}, 32'h1);
            check("liveA", {28'h0, liveA}, 32'($countones(sers(mA, mC[1]))));
            check("liveB", {28'h0, liveB}, 32'($countones(sers(mB, mC[2]))));
            xfer(1'b0, SLEC_ADDR_LANE_A, 32'h0);
            check("rdA", rd, {24'h0, mA});
            xfer(1'b0, SLEC_ADDR_STATUS, 32'h0);
            check("stat", rd, {4'h0, sers(mB, mC[2]), sers(mA, mC[1]),
                lanes(mB, mC[2]), lanes(mA, mC[1])});
        end
        xfer(1'b0, 14'h0FFC, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        summarize();
    end
endmodule : test_spare_lane_enable_control
